// *** core/nvm_access_regs.sv ***
// register front end and storage array of the nonvolatile data store
// assumes a core access port, synchronous inputs, one request per cycle
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module nvm_access_regs #(
    parameter int DEPTH       = `NVM_DEPTH,
    parameter int AW          = `NVM_ADDR_W,
    parameter int PROG_CYCLES = `NVM_PROG_TIME_US * `NVM_CLK_MHZ,
    parameter int READ_CYCLES = `NVM_READ_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire nvm_pkg::mem_req_s req,
    output logic [7:0]            rdata,
    output logic                  hit,
    input  wire logic             write_done_clear,
    output logic                  nvm_write_done_flag,
    output logic                  multi_function_request
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic                 sel_addr;
    logic                 sel_data;
    logic                 sel_ctrl;
    logic [AW-1:0]        loc_r;
    logic [7:0]           data_r;
    logic [3:0]           ctrl_r;
    logic [7:0]           store_r [DEPTH];
    logic [31:0]          cnt_r;
    logic                 done;
    nvm_pkg::nvm_state_e  state_r;

    // address/data window in bank 0 and direct in bank 1 (not indirect bank 1); control only indirect in bank 1
    assign sel_addr = (req.addr == `NVM_LOC_ADDR_OFS) && !(req.indirect && req.bank);
    assign sel_data = (req.addr == `NVM_DATA_OFS) && !(req.indirect && req.bank);
    assign sel_ctrl = req.indirect && (req.bank == `NVM_CTRL_BANK)
                      && (req.addr == `NVM_CTRL_OFS);
    assign hit = sel_addr || sel_data || sel_ctrl;
    assign done = (state_r != nvm_pkg::ST_IDLE) && (cnt_r == 32'h0);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= `NVM_RST_BYTE;
        end else if (req.rd && sel_addr) begin
            rdata <= {{(8-AW){1'b0}}, loc_r};
        end else if (req.rd && sel_data) begin
            rdata <= data_r;
        end else if (req.rd && sel_ctrl) begin
            rdata <= {4'h0, ctrl_r};
        end else begin
            rdata <= `NVM_RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // address register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loc_r <= '0;
        end else if (req.wr && sel_addr) begin
            loc_r <= req.wdata[AW-1:0];
        end
    end

    // ------------------------------------------------------------
    // data register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_r <= `NVM_RST_BYTE;
        end else if (state_r == nvm_pkg::ST_READ && done) begin
            data_r <= store_r[loc_r];
        end else if (req.wr && sel_data) begin
            data_r <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // control register and sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_r  <= 4'h0;
            state_r <= nvm_pkg::ST_IDLE;
            cnt_r   <= 32'h0;
        end else begin
            unique case (state_r)
                nvm_pkg::ST_IDLE: begin
                    if (req.wr && sel_ctrl) begin
                        ctrl_r[`NVM_BIT_WPERM] <= req.wdata[`NVM_BIT_WPERM];
                        ctrl_r[`NVM_BIT_RPERM] <= req.wdata[`NVM_BIT_RPERM];
                        // triggers take only with permit already set
                        if (req.wdata[`NVM_BIT_WTRIG] && ctrl_r[`NVM_BIT_WPERM]) begin
                            ctrl_r[`NVM_BIT_WTRIG] <= 1'b1;
                            state_r                <= nvm_pkg::ST_PROG;
                            cnt_r                  <= PROG_CYCLES - 1;
                        end else if (req.wdata[`NVM_BIT_RTRIG]
                                     && ctrl_r[`NVM_BIT_RPERM]) begin
                            ctrl_r[`NVM_BIT_RTRIG] <= 1'b1;
                            state_r                <= nvm_pkg::ST_READ;
                            cnt_r                  <= READ_CYCLES - 1;
                        end
                    end
                end
                nvm_pkg::ST_PROG, nvm_pkg::ST_READ: begin
                    if (req.wr && sel_ctrl) begin
                        ctrl_r[`NVM_BIT_WPERM] <= req.wdata[`NVM_BIT_WPERM];
                        ctrl_r[`NVM_BIT_RPERM] <= req.wdata[`NVM_BIT_RPERM];
                    end
                    if (done) begin
                        ctrl_r[`NVM_BIT_WTRIG] <= 1'b0;
                        ctrl_r[`NVM_BIT_RTRIG] <= 1'b0;
                        state_r                <= nvm_pkg::ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                default: state_r <= nvm_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // storage array, programmed at cycle end
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (state_r == nvm_pkg::ST_PROG && done) begin
            store_r[loc_r] <= data_r;
        end
    end

    // ------------------------------------------------------------
    // completion flags, set beats clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nvm_write_done_flag    <= 1'b0;
            multi_function_request <= 1'b0;
        end else if (state_r == nvm_pkg::ST_PROG && done) begin
            nvm_write_done_flag    <= 1'b1;
            multi_function_request <= 1'b1;
        end else if (write_done_clear) begin
            nvm_write_done_flag    <= 1'b0;
            multi_function_request <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // programming age, helper for the duration check
    // ------------------------------------------------------------
    logic [31:0]          prog_age_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prog_age_r <= 32'h0;
        end else if (ctrl_r[`NVM_BIT_WTRIG]) begin
            prog_age_r <= prog_age_r + 32'h1;
        end else begin
            prog_age_r <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    addr_upper_zero_a: assert property (req.rd && sel_addr |=> rdata[7:AW] == '0)
        else $error("address register upper bits not zero");
    ctrl_upper_zero_a: assert property (req.rd && sel_ctrl |=> rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    ctrl_no_direct_a: assert property (!req.indirect |-> !sel_ctrl)
        else $error("control reached directly");
    unmapped_zero_a: assert property (req.rd && !hit |=> rdata == `NVM_RST_BYTE)
        else $error("unmapped read not zero");
    wtrig_needs_perm_a: assert property (
        $rose(ctrl_r[`NVM_BIT_WTRIG]) |-> $past(ctrl_r[`NVM_BIT_WPERM]))
        else $error("write trigger set without permit");
    rtrig_needs_perm_a: assert property (
        $rose(ctrl_r[`NVM_BIT_RTRIG]) |-> $past(ctrl_r[`NVM_BIT_RPERM]))
        else $error("read trigger set without permit");
    read_ends_a: assert property (
        $rose(ctrl_r[`NVM_BIT_RTRIG]) |-> ##2 !ctrl_r[`NVM_BIT_RTRIG])
        else $error("read cycle length wrong");
    wtrig_holds_a: assert property (
        $rose(ctrl_r[`NVM_BIT_WTRIG]) |=> ctrl_r[`NVM_BIT_WTRIG] || PROG_CYCLES == 1)
        else $error("write trigger dropped early");
    prog_length_a: assert property (
        $fell(ctrl_r[`NVM_BIT_WTRIG]) |-> prog_age_r == 32'(PROG_CYCLES))
        else $error("programming time wrong");
    prog_state_a: assert property (
        (state_r == nvm_pkg::ST_PROG) == ctrl_r[`NVM_BIT_WTRIG])
        else $error("write trigger and sequencer disagree");
    read_state_a: assert property (
        (state_r == nvm_pkg::ST_READ) == ctrl_r[`NVM_BIT_RTRIG])
        else $error("read trigger and sequencer disagree");
    one_trigger_a: assert property (!(ctrl_r[`NVM_BIT_WTRIG] && ctrl_r[`NVM_BIT_RTRIG]))
        else $error("both triggers active");
    data_fetch_a: assert property (
        state_r == nvm_pkg::ST_READ && done |=> data_r == $past(store_r[loc_r]))
        else $error("fetched byte not held in data register");
    store_prog_a: assert property (
        state_r == nvm_pkg::ST_PROG && done |=> store_r[$past(loc_r)] == $past(data_r))
        else $error("programmed byte not stored");
    done_flag_set_a: assert property (
        $fell(ctrl_r[`NVM_BIT_WTRIG]) |-> nvm_write_done_flag && multi_function_request)
        else $error("write done flags not set");
    flag_hold_a: assert property (
        nvm_write_done_flag && !write_done_clear |=> nvm_write_done_flag)
        else $error("write done flag dropped without clear");
    reset_clear_a: assert property (
        $rose(nrst) |-> loc_r == '0 && data_r == 8'h00 && ctrl_r == 4'h0)
        else $error("registers not cleared by reset");

    write_seen_c:   cover property ($fell(ctrl_r[`NVM_BIT_WTRIG]));
    read_seen_c:    cover property ($fell(ctrl_r[`NVM_BIT_RTRIG]));
    refused_c:      cover property (req.wr && sel_ctrl && req.wdata[`NVM_BIT_WTRIG]
                                    && !ctrl_r[`NVM_BIT_WPERM]);
    rd_refused_c:   cover property (req.wr && sel_ctrl && req.wdata[`NVM_BIT_RTRIG]
                                    && !ctrl_r[`NVM_BIT_RPERM]);
    flag_cleared_c: cover property ($fell(nvm_write_done_flag));
endmodule // nvm_access_regs

// *** include/nvm_cfg.svh ***
// constants for the nonvolatile data store register front end
// assumes the core presents a data-memory access port with a bank bit
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH
`define NVM_DEPTH        64
`define NVM_ADDR_W       6
`define NVM_LOC_ADDR_OFS 8'h40
`define NVM_DATA_OFS     8'h41
`define NVM_CTRL_OFS     8'h40
`define NVM_CTRL_BANK    1'b1
`define NVM_BIT_WPERM    3
`define NVM_BIT_WTRIG    2
`define NVM_BIT_RPERM    1
`define NVM_BIT_RTRIG    0
`define NVM_RST_BYTE     8'h00
`define NVM_PROG_TIME_US 2000
`define NVM_CLK_MHZ      100
`define NVM_READ_CYCLES  2
`endif

// *** include/nvm_pkg.sv ***
// types for the nonvolatile data store register front end
// assumes nvm_cfg.svh supplies the numbers
package nvm_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       indirect;
        logic       bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_PROG = 3'b100
    } nvm_state_e;
endpackage

// *** verif/tb.sv ***
// bench for the nonvolatile store register front end
// assumes nvm_pkg is compiled first; drives the access port itself
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int PROG  = 8;
    localparam int LIMIT = 20000;
    logic              clk;
    logic              nrst;
    nvm_pkg::mem_req_s req;
    logic [7:0]        rdata;
    logic              hit;
    logic              write_done_clear;
    logic              nvm_write_done_flag;
    logic              multi_function_request;
    int                fail_count;
    int                total_checks;
    int                cycles;
    logic [7:0]        mem_model [64];
    logic [5:0]        addr_list [6];
    logic [7:0]        rd_v;
    logic [7:0]        d;
    logic [5:0]        a;

    nvm_access_regs #(.PROG_CYCLES(PROG), .READ_CYCLES(2)) u_dut (
        .clk                    (clk),
        .nrst                   (nrst),
        .req                    (req),
        .rdata                  (rdata),
        .hit                    (hit),
        .write_done_clear       (write_done_clear),
        .nvm_write_done_flag    (nvm_write_done_flag),
        .multi_function_request (multi_function_request)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_loc(input logic [7:0] v);
        return {2'b00, v[5:0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic i, input logic b, input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk);
        req <= '{1'b1, 1'b0, i, b, ad, v};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd_reg(input logic i, input logic b, input logic [7:0] ad, input logic h,
                          output logic [7:0] v);
        @(posedge clk);
        req <= '{1'b0, 1'b1, i, b, ad, 8'h00};
        #1;
        chk("hit", {7'h00, h}, {7'h00, hit});
        @(posedge clk);
        req <= '0;
        #1;
        v = rdata;
    endtask
    task automatic wait_clear(input int b);
        logic [7:0] v;
        for (int n = 0; n < 40; n++) begin
            rd_reg(1'b1, 1'b1, 8'h40, 1'b1, v);
            if (v[b] === 1'b0) break;
        end
        chk("trigger_clear", 8'h00, {7'h00, v[b]});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        total_checks = 0;
        cycles = 0;
        nrst = 1'b0;
        req = '0;
        write_done_clear = 1'b0;
        void'($urandom(40));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(1'b0, 1'b0, 8'h40, 1'b1, rd_v);
        chk("loc_rst", 8'h00, rd_v);
        rd_reg(1'b0, 1'b0, 8'h41, 1'b1, rd_v);
        chk("data_rst", 8'h00, rd_v);
        rd_reg(1'b1, 1'b1, 8'h40, 1'b1, rd_v);
        chk("ctrl_rst", 8'h00, rd_v);
        rd_reg(1'b0, 1'b0, 8'h42, 1'b0, rd_v);
        chk("unmapped", 8'h00, rd_v);
        rd_reg(1'b1, 1'b1, 8'h41, 1'b0, rd_v);
        chk("bank1_data", 8'h00, rd_v);
        wr_reg(1'b0, 1'b1, 8'h40, 8'hFF);
        rd_reg(1'b0, 1'b1, 8'h40, 1'b1, rd_v);
        chk("loc_mask", exp_loc(8'hFF), rd_v);
        rd_reg(1'b1, 1'b0, 8'h40, 1'b1, rd_v);
        chk("loc_ind_bank0", exp_loc(8'hFF), rd_v);
        wr_reg(1'b1, 1'b1, 8'h40, 8'hF4);
        rd_reg(1'b1, 1'b1, 8'h40, 1'b1, rd_v);
        chk("no_wpermit", 8'h00, rd_v);
        wr_reg(1'b1, 1'b1, 8'h40, 8'hF1);
        rd_reg(1'b1, 1'b1, 8'h40, 1'b1, rd_v);
        chk("no_rpermit", 8'h00, rd_v);
        wr_reg(1'b1, 1'b1, 8'h40, 8'hFA);
        rd_reg(1'b1, 1'b1, 8'h40, 1'b1, rd_v);
        chk("permits", 8'h0A, rd_v);
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
            d = 8'($urandom);
            addr_list[i] = a;
            mem_model[a] = d;
            wr_reg(1'b0, 1'b0, 8'h40, {2'b00, a});
            wr_reg(1'b0, 1'b0, 8'h41, d);
            rd_reg(1'b0, 1'b0, 8'h41, 1'b1, rd_v);
            chk("data_rw", d, rd_v);
            wr_reg(1'b1, 1'b1, 8'h40, 8'h08);
            wr_reg(1'b1, 1'b1, 8'h40, 8'h0C);
            rd_reg(1'b1, 1'b1, 8'h40, 1'b1, rd_v);
            chk("prog_busy", 8'h0C, rd_v);
            wait_clear(2);
            chk("done_flag", 8'h01, {7'h00, nvm_write_done_flag});
            chk("mf_req", 8'h01, {7'h00, multi_function_request});
            @(posedge clk);
            write_done_clear <= 1'b1;
            @(posedge clk);
            write_done_clear <= 1'b0;
            @(posedge clk);
            #1;
            chk("flag_clr", 8'h00, {7'h00, nvm_write_done_flag});
            chk("mf_clr", 8'h00, {7'h00, multi_function_request});
        end
        for (int i = 0; i < 6; i++) begin
            wr_reg(1'b0, 1'b0, 8'h40, {2'b00, addr_list[i]});
            wr_reg(1'b0, 1'b0, 8'h41, ~mem_model[addr_list[i]]);
            wr_reg(1'b1, 1'b1, 8'h40, 8'h02);
            wr_reg(1'b1, 1'b1, 8'h40, 8'h03);
            wait_clear(0);
            rd_reg(1'b0, 1'b0, 8'h41, 1'b1, rd_v);
            chk("fetched", mem_model[addr_list[i]], rd_v);
        end
        print_verdict();
    end
endmodule // tb
